// [tb.sv]
// Self-checking bench for the two-wire debug target.
// Assumes the host model drives the link and the bench plays the flash engine.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("wrong value %s expected %h seen %h", nm, (e), (g)); \
	end \
end
module tb;
	// ****************************************
	// Signals and instances
	// ****************************************
	localparam logic [7:0] EXP_PART = 8'h5A; // Arbitrary value
	localparam logic [7:0] EXP_REV = 8'hA5; // Arbitrary value
	logic ref_clk_i, reset_i, lclk, line, dd_o, dd_oe, halted, owned;
	logic wvalid, wready, iscmd, rvalid;
	logic [7:0] fpc, word, rdata, v;
	int n_mismatch = 0;
	int comparisons = 0;
	twd_host host (.debug_clock_line_o(lclk), .line_o(line), .dev_d_i(dd_o), .dev_oe_i(dd_oe));
	twd_target #(.PART_ID(EXP_PART), .REV_ID(EXP_REV)) uut (.ref_clk_i(ref_clk_i),
		.reset_i(reset_i), .debug_clock_line_i(lclk), .debug_data_line_i(line),
		.debug_data_line_o(dd_o), .debug_data_line_oe_o(dd_oe), .halted_i(halted),
		.shared_port_pin_owned_o(owned), .flash_program_control_o(fpc), .fp_word_o(word),
		.fp_word_valid_o(wvalid), .fp_word_ready_i(wready), .fp_word_is_cmd_o(iscmd),
		.fp_read_data_i(rdata), .fp_read_valid_i(rvalid));
	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic wrap_up();
		$display("compared %0d, wrong %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up
	task automatic link(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rv);
		bit ok;
		host.xfer(ins, wd, rv, ok);
		`CHK("ready seen", 1'b1, ok)
		`CHK("oe after frame", 1'b0, dd_oe)
		if (!ok)
			wrap_up();
	endtask : link
	task automatic sel(input logic [7:0] a);
		logic [7:0] d;
		link(twd_pkg::INS_ADDR_WRITE, a, d);
	endtask : sel
	task automatic wr(input logic [7:0] d);
		logic [7:0] x;
		link(twd_pkg::INS_DATA_WRITE, d, x);
	endtask : wr
	task automatic pop();
		@(negedge ref_clk_i) wready = 1'b1;
		@(negedge ref_clk_i) wready = 1'b0;
	endtask : pop
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		`CHK("oe", 1'b0, dd_oe)
		`CHK("data out", 1'b1, dd_o)
		`CHK("valid", 1'b0, wvalid)
		`CHK("control", 8'h00, fpc)
		@(negedge ref_clk_i) halted = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		`CHK("owned", 1'b1, owned)
		$display("test reset done");
	endtask : t_reset
	task automatic t_ident();
		sel(twd_pkg::SEL_PART);
		link(twd_pkg::INS_DATA_READ, 8'h00, v);
		`CHK("part id", EXP_PART, v)
		wr(8'h3C);
		link(twd_pkg::INS_DATA_READ, 8'h00, v);
		`CHK("part id kept", EXP_PART, v)
		link(twd_pkg::INS_ADDR_READ, 8'h00, v);
		`CHK("select", 8'h00, v)
		sel(twd_pkg::SEL_REV);
		link(twd_pkg::INS_DATA_READ, 8'h00, v);
		`CHK("rev id", EXP_REV, v)
		link(twd_pkg::INS_ADDR_READ, 8'h00, v);
		`CHK("select", 8'h01, v)
		sel(8'h77);
		link(twd_pkg::INS_DATA_READ, 8'h00, v);
		`CHK("unknown sel", 8'h00, v)
		$display("test ident done");
	endtask : t_ident
	task automatic t_ctrl();
		sel(twd_pkg::SEL_FP_CTL);
		wr(8'h3C);
		`CHK("control", 8'h3C, fpc)
		link(twd_pkg::INS_DATA_READ, 8'h00, v);
		`CHK("control rd", 8'h3C, v)
		wr(8'hC3);
		`CHK("control", 8'hC3, fpc)
		$display("test control done");
	endtask : t_ctrl
	task automatic t_data();
		sel(twd_pkg::SEL_FP_DAT);
		wr(twd_pkg::CMD_BLOCK_READ);
		wr(twd_pkg::CMD_BLOCK_WRITE);
		`CHK("head", 8'h06, word)
		`CHK("cmd flag", 1'b1, iscmd)
		fork
			wr(twd_pkg::CMD_PAGE_ERASE);
			begin
				repeat (100) @(negedge ref_clk_i);
				pop();
			end
		join
		`CHK("head", 8'h07, word)
		pop();
		`CHK("head", twd_pkg::CMD_PAGE_ERASE, word)
		`CHK("cmd flag", 1'b1, iscmd)
		pop();
		wr(twd_pkg::CMD_DEVICE_ERASE);
		`CHK("cmd flag", 1'b1, iscmd)
		wr(8'h55);
		pop();
		`CHK("head", 8'h55, word)
		`CHK("cmd flag", 1'b0, iscmd)
		pop();
		`CHK("valid", 1'b0, wvalid)
		@(negedge ref_clk_i) rdata = 8'hC3;
		rvalid = 1'b1;
		@(negedge ref_clk_i) rvalid = 1'b0;
		link(twd_pkg::INS_DATA_READ, 8'h00, v);
		`CHK("data rd", 8'hC3, v)
		$display("test data done");
	endtask : t_data
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		reset_i = 1'b0;
		halted = 1'b0;
		wready = 1'b0;
		rvalid = 1'b0;
		rdata = 8'h00;
		// Clean rising edge once every reset process is waiting
		#1 reset_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		reset_i = 1'b0;
		host.idle(4);
		t_reset();
		t_ident();
		t_ctrl();
		t_data();
		@(negedge ref_clk_i) halted = 1'b0;
		repeat (4) @(negedge ref_clk_i);
		`CHK("owned", 1'b0, owned)
		wrap_up();
	end
endmodule : tb
`default_nettype wire

// [twd_host_model.sv]
// Behavioural debug host: clocks frames on the link and shares the data wire.
// Assumes a pull-up on the data wire and a target that samples on rising link edges.
`timescale 1ns/1ps
`default_nettype none
module twd_host (
	output logic debug_clock_line_o, // Link clock, still between frames
	output logic line_o, // Resolved data wire
	input wire logic dev_d_i, // Target drive value
	input wire logic dev_oe_i // Target drive enable
);
	// ****************************************
	// Wire and clock
	// ****************************************
	logic hd;
	logic host_oe;
	initial begin
		debug_clock_line_o = 1'b0;
		hd = 1'b1;
		host_oe = 1'b0;
	end
	// Pull-up wins when nobody drives
	assign line_o = dev_oe_i ? dev_d_i : (host_oe ? hd : 1'b1);
	task automatic tick();
		#17 debug_clock_line_o = 1'b1;
		#15 debug_clock_line_o = 1'b0;
	endtask : tick
	task automatic idle(input int n);
		host_oe = 1'b0;
		repeat (n) tick();
	endtask : idle
	// ****************************************
	// One frame; ok drops if ready never comes
	// ****************************************
	task automatic xfer(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd,
		output bit ok);
		int n;
		rd = 8'h00;
		ok = 1'b1;
		host_oe = 1'b1;
		hd = 1'b0;
		tick();
		for (int i = 0; i < 2; i++) begin
			hd = ins[i];
			tick();
		end
		if (ins == twd_pkg::INS_ADDR_WRITE || ins == twd_pkg::INS_DATA_WRITE) begin
			for (int i = 0; i < 8; i++) begin
				hd = wd[i];
				tick();
			end
		end
		host_oe = 1'b0;
		if (ins != twd_pkg::INS_ADDR_WRITE) begin
			n = 0;
			while (!(dev_oe_i && dev_d_i) && n < 200) begin
				tick();
				n++;
			end
			ok = (n < 200);
			if (ins != twd_pkg::INS_DATA_WRITE) begin
				for (int i = 0; i < 8; i++) begin
					tick();
					rd[i] = line_o;
				end
			end
			tick();
		end
		tick();
	endtask : xfer
endmodule : twd_host
`default_nettype wire

// [twd_pkg.sv]
// Constants shared by the two-wire debug target: selector codes, flash
// command codes, link instruction codes and the link state type.
// Assumes a single clock domain for the register side and one link clock.
package twd_pkg;
	localparam logic [7:0] SEL_PART = 8'h00;
	localparam logic [7:0] SEL_REV = 8'h01;
	localparam logic [7:0] SEL_FP_CTL = 8'h02;
	localparam logic [7:0] SEL_FP_DAT = 8'hB4;
	localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
	localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
	localparam logic [7:0] CMD_PAGE_ERASE = CMD_BLOCK_WRITE + 8'h01; // Code after block write
	localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;
	localparam logic [7:0] RST_TARGET_SELECT = 8'h00;
	localparam logic [7:0] RST_FP_CTL = 8'h00;
	localparam logic [7:0] RST_FP_DAT = 8'h00;
	localparam logic [1:0] INS_DATA_READ = 2'h0;
	localparam logic [1:0] INS_ADDR_WRITE = 2'h1;
	localparam logic [1:0] INS_DATA_WRITE = 2'h2;
	localparam logic [1:0] INS_ADDR_READ = 2'h3;
	localparam logic [2:0] LAST_BIT = 3'h7;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_INSTR,
		ST_PAYLOAD,
		ST_WAIT,
		ST_READY,
		ST_REPLY
	} twd_state_t;
endpackage : twd_pkg

// [twd_target.sv]
// Target side of the two-wire debug and flash programming link.
// Assumes the host clocks the link on the reset pin and shares the data pin.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Link uses host clock and one data line
// - Host writes eight-bit target select register
// - Select 0x00 reads part identifier
// - Select 0x01 reads revision identifier
// - Select 0x02 reaches flash program control
// - Select 0xB4 reaches flash program data
// - Part identifier is fixed read-only code
// - Flash data register carries commands, addresses, data
// - Block read, write, page erase, device erase codes
// - Traffic normally while device halted
// - Clock from reset pin, data from port
module twd_target #(
	parameter logic [7:0] PART_ID = 8'h5A, // Arbitrary value
	parameter logic [7:0] REV_ID = 8'hA5 // Arbitrary value
) (
	input wire logic ref_clk_i, // Core clock
	input wire logic reset_i, // Async reset, high
	input wire logic debug_clock_line_i, // Link clock from reset pin
	input wire logic debug_data_line_i, // Shared data pin input
	output logic debug_data_line_o, // Shared data pin output
	output logic debug_data_line_oe_o, // High while device drives pin
	input wire logic halted_i, // Core halted level
	output logic shared_port_pin_owned_o, // Link owns shared pins
	output logic [7:0] flash_program_control_o, // Control register value
	output logic [7:0] fp_word_o, // Buffered flash data word
	output logic fp_word_valid_o, // Buffered word present
	input wire logic fp_word_ready_i, // Flash engine takes word
	output logic fp_word_is_cmd_o, // Head word is a valid command
	input wire logic [7:0] fp_read_data_i, // Flash engine read byte
	input wire logic fp_read_valid_i // Load read byte into data register
);
	// ****************************************
	// Link domain
	// ****************************************
	logic lrst_q1;
	logic lrst;
	twd_pkg::twd_state_t state;
	logic [2:0] cnt;
	logic [1:0] instr;
	logic [7:0] shreg;
	logic [7:0] target_select;
	logic req_t;
	logic req_write;
	logic [7:0] req_addr;
	logic [7:0] req_data;
	logic ack_s1;
	logic ack_s2;
	logic ack_t;
	logic link_done;
	logic [7:0] rd_result;
	logic [1:0] next_instr;
	logic [7:0] next_byte;

	assign link_done = (req_t == ack_s2);
	assign next_instr = {debug_data_line_i, instr[0]};
	assign next_byte = {debug_data_line_i, shreg[6:0]};

	always_ff @(posedge debug_clock_line_i or posedge reset_i) begin
		if (reset_i) begin
			lrst_q1 <= 1'b1;
			lrst <= 1'b1;
		end else begin
			lrst_q1 <= 1'b0;
			lrst <= lrst_q1;
		end
	end

	always_ff @(posedge debug_clock_line_i or posedge lrst) begin
		if (lrst) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			ack_s1 <= ack_t;
			ack_s2 <= ack_s1;
		end
	end

	// Frame: start low, two instruction bits, payload, wait bits, reply
	always_ff @(posedge debug_clock_line_i or posedge lrst) begin
		if (lrst) begin
			state <= twd_pkg::ST_IDLE;
			cnt <= 3'h0;
			instr <= 2'h0;
			shreg <= 8'h00;
			target_select <= twd_pkg::RST_TARGET_SELECT;
			req_t <= 1'b0;
			req_write <= 1'b0;
			req_addr <= 8'h00;
			req_data <= 8'h00;
			debug_data_line_o <= 1'b1;
			debug_data_line_oe_o <= 1'b0;
		end else begin
			unique case (state)
				twd_pkg::ST_IDLE: begin
					debug_data_line_oe_o <= 1'b0;
					cnt <= 3'h0;
					if (!debug_data_line_i) begin
						state <= twd_pkg::ST_INSTR;
					end
				end
				twd_pkg::ST_INSTR: begin
					instr[cnt[0]] <= debug_data_line_i;
					cnt <= cnt + 3'h1;
					if (cnt[0]) begin
						cnt <= 3'h0;
						if (next_instr == twd_pkg::INS_ADDR_READ) begin
							shreg <= target_select;
							debug_data_line_o <= 1'b1;
							debug_data_line_oe_o <= 1'b1;
							state <= twd_pkg::ST_READY;
						end else if (next_instr == twd_pkg::INS_DATA_READ) begin
							req_write <= 1'b0;
							req_addr <= target_select;
							req_t <= ~req_t;
							debug_data_line_o <= 1'b0;
							debug_data_line_oe_o <= 1'b1;
							state <= twd_pkg::ST_WAIT;
						end else begin
							state <= twd_pkg::ST_PAYLOAD;
						end
					end
				end
				twd_pkg::ST_PAYLOAD: begin
					shreg[cnt] <= debug_data_line_i;
					cnt <= cnt + 3'h1;
					if (cnt == twd_pkg::LAST_BIT) begin
						if (instr == twd_pkg::INS_ADDR_WRITE) begin
							target_select <= next_byte;
							state <= twd_pkg::ST_IDLE;
						end else begin
							req_write <= 1'b1;
							req_addr <= target_select;
							req_data <= next_byte;
							req_t <= ~req_t;
							debug_data_line_o <= 1'b0;
							debug_data_line_oe_o <= 1'b1;
							state <= twd_pkg::ST_WAIT;
						end
					end
				end
				twd_pkg::ST_WAIT: begin
					if (link_done) begin
						debug_data_line_o <= 1'b1;
						shreg <= rd_result;
						state <= twd_pkg::ST_READY;
					end
				end
				twd_pkg::ST_READY: begin
					cnt <= 3'h0;
					if (instr == twd_pkg::INS_DATA_WRITE) begin
						debug_data_line_oe_o <= 1'b0;
						state <= twd_pkg::ST_IDLE;
					end else begin
						debug_data_line_o <= shreg[0];
						state <= twd_pkg::ST_REPLY;
					end
				end
				twd_pkg::ST_REPLY: begin
					if (cnt == twd_pkg::LAST_BIT) begin
						debug_data_line_oe_o <= 1'b0;
						state <= twd_pkg::ST_IDLE;
					end else begin
						debug_data_line_o <= shreg[cnt + 3'h1];
						cnt <= cnt + 3'h1;
					end
				end
			endcase
		end
	end

	AST_SEL_WRITE: assert property (@(posedge debug_clock_line_i) disable iff (lrst)
		(state == twd_pkg::ST_PAYLOAD && cnt == twd_pkg::LAST_BIT
		&& instr == twd_pkg::INS_ADDR_WRITE)
		|=> target_select == {$past(debug_data_line_i), $past(shreg[6:0])})
		else $error("target select not loaded");
	AST_SEL_HOLD: assert property (@(posedge debug_clock_line_i) disable iff (lrst)
		!($past(state) == twd_pkg::ST_PAYLOAD && $past(instr) == twd_pkg::INS_ADDR_WRITE)
		|-> $stable(target_select))
		else $error("target select changed without write");
	AST_DRIVE_PHASE: assert property (@(posedge debug_clock_line_i) disable iff (lrst)
		debug_data_line_oe_o |-> (state == twd_pkg::ST_WAIT || state == twd_pkg::ST_READY
		|| state == twd_pkg::ST_REPLY || $past(state) == twd_pkg::ST_REPLY))
		else $error("data line driven outside reply");

	// ****************************************
	// Core domain
	// ****************************************
	logic req_s1;
	logic req_s2;
	logic core_pending;
	logic is_fpd;
	logic take_req;
	logic [7:0] fp_data;
	logic halt_s1;
	logic halt_s2;
	logic [7:0] fifo_mem [2];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] fifo_cnt;
	logic fifo_ready;
	logic push;
	logic pop;

	function automatic logic valid_cmd(input logic [7:0] code);
		valid_cmd = (code == twd_pkg::CMD_BLOCK_READ) || (code == twd_pkg::CMD_BLOCK_WRITE)
			|| (code == twd_pkg::CMD_PAGE_ERASE) || (code == twd_pkg::CMD_DEVICE_ERASE);
	endfunction : valid_cmd

	assign core_pending = (req_s2 != ack_t);
	assign is_fpd = (req_addr == twd_pkg::SEL_FP_DAT);
	assign fifo_ready = (fifo_cnt != 2'h2);
	// A write to the data register stalls the link while the buffer is full
	assign take_req = core_pending && !(req_write && is_fpd && !fifo_ready);
	assign push = take_req && req_write && is_fpd;
	assign fp_word_valid_o = (fifo_cnt != 2'h0);
	assign pop = fp_word_valid_o && fp_word_ready_i;
	assign fp_word_o = fifo_mem[rd_ptr];
	assign fp_word_is_cmd_o = fp_word_valid_o && valid_cmd(fifo_mem[rd_ptr]);

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			halt_s1 <= 1'b0;
			halt_s2 <= 1'b0;
			shared_port_pin_owned_o <= 1'b0;
		end else begin
			req_s1 <= req_t;
			req_s2 <= req_s1;
			halt_s1 <= halted_i;
			halt_s2 <= halt_s1;
			shared_port_pin_owned_o <= halt_s2;
		end
	end

	// Request fields stay still from toggle until acknowledge returns
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ack_t <= 1'b0;
			rd_result <= 8'h00;
		end else if (take_req) begin
			ack_t <= ~ack_t;
			if (!req_write) begin
				unique case (req_addr)
					twd_pkg::SEL_PART: rd_result <= PART_ID;
					twd_pkg::SEL_REV: rd_result <= REV_ID;
					twd_pkg::SEL_FP_CTL: rd_result <= flash_program_control_o;
					twd_pkg::SEL_FP_DAT: rd_result <= fp_data;
					default: rd_result <= 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			flash_program_control_o <= twd_pkg::RST_FP_CTL;
		end else if (take_req && req_write && req_addr == twd_pkg::SEL_FP_CTL) begin
			flash_program_control_o <= req_data;
		end
	end

	// Engine read data overrides a link write in the same cycle
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			fp_data <= twd_pkg::RST_FP_DAT;
		end else if (fp_read_valid_i) begin
			fp_data <= fp_read_data_i;
		end else if (push) begin
			fp_data <= req_data;
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			fifo_mem[0] <= 8'h00;
			fifo_mem[1] <= 8'h00;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			fifo_cnt <= 2'h0;
		end else begin
			if (push) begin
				fifo_mem[wr_ptr] <= req_data;
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
		end
	end

	AST_PART_READ: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(take_req && !req_write && req_addr == twd_pkg::SEL_PART) |=> rd_result == PART_ID)
		else $error("part identifier not returned");
	AST_REV_READ: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(take_req && !req_write && req_addr == twd_pkg::SEL_REV) |=> rd_result == REV_ID)
		else $error("revision identifier not returned");
	AST_CTL_WRITE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(take_req && req_write && req_addr == twd_pkg::SEL_FP_CTL)
		|=> flash_program_control_o == $past(req_data))
		else $error("control register not written");
	AST_FPD_PUSH: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(core_pending && req_write && is_fpd && fifo_ready && !fp_word_ready_i)
		|=> fp_word_valid_o && fifo_cnt == $past(fifo_cnt) + 2'h1)
		else $error("data word not buffered");
	AST_STALL_FULL: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(core_pending && req_write && is_fpd && fifo_cnt == 2'h2) |=> $stable(ack_t))
		else $error("write acknowledged while buffer full");
	AST_CMD_FLAG: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(fp_word_valid_o && fp_word_o == twd_pkg::CMD_PAGE_ERASE) |-> fp_word_is_cmd_o)
		else $error("page erase code not flagged");
	AST_PIN_OWN: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		halted_i [*4] |-> shared_port_pin_owned_o)
		else $error("shared pins not owned while halted");
endmodule : twd_target

`default_nettype wire
